// ### test/mux_adc_seq_config_tb_top.sv
/*
 Self-checking bench for mxcfg_top: registers over Avalon-MM, field pins,
 sequencer modes, timing and calibration. Assumes the design and checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mxcfg_defines.vh"

module mux_adc_seq_config_tb_top;
localparam logic [7:0] c_one = `MXC_IDX_CFG_ONE;
logic core_clk = 1'b0;
logic sys_rst = 1'b1;
logic avs_read = 1'b0;
logic avs_write = 1'b0;
logic power_down = 1'b0;
logic current_conv_data_ready_n = 1'b1;
logic [9:0] avs_address = 10'h000;
logic [31:0] avs_writedata = 32'h00000000;
logic [3:0] avs_byteenable = 4'hF;
logic [3:0] step_enable = 4'h1;
logic [1:0] mux_converter_gain = 2'h0;
logic [15:0] raw_sample = 16'h0000;
logic [15:0] fx;
wire [31:0] avs_readdata;
wire [15:0] conv_result;
wire [2:0] test_source_route, test_sink_route;
wire [1:0] test_source_level, test_sink_level, oversampling_select, sequence_step_counter;
wire avs_waitrequest, mux_converter_enable, common_mode_buffer_enable;
wire conv_start, result_valid, seq_busy;
wire [15:0] one_out = {4'h0, mux_converter_enable, common_mode_buffer_enable,
    test_source_route, test_sink_route, test_source_level, test_sink_level};
int err_count = 0;
int checks = 0;
int cyc = 0;
int tp, t0, t1, k;
// Offset, gain word, gain input, raw sample, expected result
logic [15:0] cal [6][5] = '{'{16'h0010, 16'h0000, 16'h0000, 16'h1000, 16'h0FF0},
    '{16'h0010, 16'h0000, 16'h0002, 16'h1000, 16'h0FE0},
    '{16'h0000, 16'h7FFF, 16'h0000, 16'h2000, 16'h2FFF},
    '{16'h0000, 16'h7FFF, 16'h0000, 16'h7000, 16'h7FFF},
    '{16'h0001, 16'h0000, 16'h0000, 16'h8000, 16'h8000},
    '{16'h0000, 16'h8000, 16'h0000, 16'h4000, 16'h2000}};
int settle [8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
int conv [4] = '{384, 512, 768, 1280};
logic [7:0] ridx [6] = '{8'hCC, 8'hCD, 8'hCE, 8'hCF, 8'h10, 8'hCB};
logic [15:0] rwd [6] = '{16'hFFFF, 16'hFFFF, 16'hA5C3, 16'h5A3C, 16'hFFFF, 16'h7FFF};
logic [15:0] rexp [6] = '{16'hC703, 16'h00FF, 16'hA5C3, 16'h5A3C, 16'h0000, 16'h07FF};

mxcfg_top #(.NSTEPS(4)) dut (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .power_down,
    .current_conv_data_ready_n, .step_enable, .mux_converter_gain, .raw_sample,
    .mux_converter_enable, .common_mode_buffer_enable, .test_source_route, .test_sink_route,
    .test_source_level, .test_sink_level, .oversampling_select, .sequence_step_counter,
    .conv_start, .result_valid, .conv_result, .seq_busy);

initial forever #50 core_clk = ~core_clk;
always @(posedge core_clk) cyc <= cyc + 1;
// ****************************************************************
// Tasks
// ****************************************************************
task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
        err_count++;
        $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
endtask
task automatic timeout;
    err_count++;
    $display("MISMATCH %0t wait ran out", $time);
    results();
endtask
// Holds the request until waitrequest is sampled low, then releases it
task automatic bus(input logic rd, input logic [7:0] i, input logic [15:0] d,
    output logic [15:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {16'h0000, d};
    avs_read <= rd;
    avs_write <= !rd;
    do begin
        @(posedge core_clk);
        n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) timeout();
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
endtask
task automatic wr(input logic [7:0] i, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b0, i, d, q);
endtask
task automatic rd(input logic [7:0] i, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b1, i, 16'h0000, q);
    chk(q, e, "read");
endtask
task automatic wait_on(input int s);
    int n;
    n = 0;
    do begin
        @(posedge core_clk);
        n++;
    end while (((s == 0) ? conv_start : (s == 1) ? result_valid : !seq_busy) !== 1'b1
        && n < 6000);
    if (n >= 6000) timeout();
endtask
task automatic count(input int c, output int r);
    r = 0;
    repeat (c) begin
        @(posedge core_clk);
        if (result_valid === 1'b1) r++;
    end
endtask
// Configuration changes only while the converter is off
task automatic setup(input logic [15:0] c2, input logic [15:0] off, input logic [15:0] gn);
    wr(c_one, 16'h0010);
    wr(`MXC_IDX_CFG_TWO, c2);
    wr(`MXC_IDX_OFFSET, off);
    wr(`MXC_IDX_GAIN, gn);
    wr(c_one, 16'h8010);
endtask
task automatic start;
    wr(`MXC_IDX_CTRL, 16'h0001);
endtask
// ****************************************************************
// Main sequence
// ****************************************************************
initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(c_one, 16'h8010);
    chk(one_out, 16'h0810, "reset pins");
    for (int i = 8'hCC; i <= 8'hCF; i++) rd(8'(i), 16'h0000);
    wr(c_one, 16'h0010);
    for (int i = 0; i < 6; i++) begin
        wr(ridx[i], rwd[i]);
        rd(ridx[i], rexp[i]);
    end
    for (int i = 0; i < 8; i++) begin
        fx = {5'h00, i[0], 3'(i), 3'(7 - i), 2'(i), 2'(3 - i)};
        wr(c_one, fx);
        @(negedge core_clk);
        chk(one_out, fx, "fields");
    end
    for (int i = 0; i < 6; i++) begin
        setup(16'h0000, cal[i][0], cal[i][1]);
        mux_converter_gain <= cal[i][2][1:0];
        raw_sample <= cal[i][3];
        start();
        t0 = cyc;
        wait_on(1);
        if (i == 0) tp = cyc - t0;
        chk(conv_result, cal[i][4], "calibrated");
        rd(`MXC_IDX_RESULT, cal[i][4]);
    end
    wait_on(2);
    rd(`MXC_IDX_CTRL, 16'h0000);
    count(600, k);
    chk(16'(k), 16'h0000, "extra pass");
    start();
    repeat (100) @(posedge core_clk);
    start();
    t0 = cyc;
    wait_on(1);
    chk(16'(cyc - t0), 16'(tp), "restart");
    step_enable <= 4'h3;
    for (int i = 0; i < 8; i++) begin
        setup({5'h00, 3'(i), 6'h00, 2'(i)}, 16'h0000, 16'h0000);
        start();
        wait_on(0);
        t0 = cyc;
        wait_on(1);
        t1 = cyc;
        chk(16'(t1 - t0), 16'(conv[i % 4]), "conversion");
        wait_on(0);
        chk(16'(cyc - t1), 16'(settle[i]), "settle");
    end
    step_enable <= 4'h2;
    for (int m = 2; m < 4; m++) begin
        setup({2'(m), 14'h0000}, 16'h0000, 16'h0000);
        start();
        count(1300, k);
        chk(16'(k), 16'h0003, "repeats");
    end
    wr(c_one, 16'h0010);
    repeat (2) @(negedge core_clk);
    chk(conv_result, 16'h0000, "off result");
    chk({14'h0, sequence_step_counter}, 16'h0000, "off count");
    wr(c_one, 16'h8010);
    start();
    count(500, k);
    power_down <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk({conv_result[15:1], conv_result[0] | seq_busy}, 16'h0000, "standby");
    start();
    count(500, k);
    chk(16'(k), 16'h0000, "standby start");
    power_down <= 1'b0;
    setup({2'b01, 14'h0000}, 16'h0000, 16'h0000);
    current_conv_data_ready_n <= 1'b0;
    t0 = cyc;
    wait_on(1);
    t1 = cyc - t0;
    current_conv_data_ready_n <= 1'b1;
    wait_on(2);
    repeat (4) @(posedge core_clk);
    current_conv_data_ready_n <= 1'b0;
    t0 = cyc;
    repeat (100) @(posedge core_clk);
    current_conv_data_ready_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    current_conv_data_ready_n <= 1'b0;
    wait_on(1);
    chk(16'(cyc - t0), 16'(t1), "trigger");
    count(900, k);
    chk(16'(k), 16'h0000, "retrigger");
    results();
end
endmodule // mux_adc_seq_config_tb_top

bind mxcfg_top mxcfg_properties chk_i (.core_clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .power_down,
    .mux_converter_enable, .common_mode_buffer_enable, .test_source_route, .test_sink_route,
    .test_source_level, .test_sink_level, .oversampling_select, .sequence_step_counter,
    .conv_start, .result_valid, .conv_result, .seq_busy);
`default_nettype wire

// ### test/mxcfg_properties.sv
/*
 Checker for mxcfg_top: bus wait state, field mirrors, clearing and timing.
 Assumes it is bound to mxcfg_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mxcfg_defines.vh"

module mxcfg_properties (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic power_down,
    input wire logic mux_converter_enable,
    input wire logic common_mode_buffer_enable,
    input wire logic [2:0] test_source_route,
    input wire logic [2:0] test_sink_route,
    input wire logic [1:0] test_source_level,
    input wire logic [1:0] test_sink_level,
    input wire logic [1:0] oversampling_select,
    input wire logic [1:0] sequence_step_counter,
    input wire logic conv_start,
    input wire logic result_valid,
    input wire logic [15:0] conv_result,
    input wire logic seq_busy
);
default clocking @(posedge core_clk); endclocking
default disable iff (sys_rst);
// ****************************************************************
// Helpers
// ****************************************************************
wire [7:0] idx = avs_address[9:2];
wire done = (avs_read || avs_write) && !avs_waitrequest;
wire be_full = avs_byteenable[1:0] == 2'b11;
wire wr_one = avs_write && done && idx == `MXC_IDX_CFG_ONE;
wire wr_two = avs_write && done && be_full && idx == `MXC_IDX_CFG_TWO;
wire [11:0] one_wd = {avs_writedata[15], avs_writedata[10:0]};
wire [11:0] one_out = {mux_converter_enable, common_mode_buffer_enable, test_source_route,
    test_sink_route, test_source_level, test_sink_level};
wire [1:0] osr_wd = avs_writedata[1:0];
// Bits that must read zero at the addressed register
wire [15:0] rsv = (idx == `MXC_IDX_CFG_ONE) ? ~`MXC_CFG_ONE_MASK :
    (idx == `MXC_IDX_CFG_TWO) ? ~`MXC_CFG_TWO_MASK :
    (idx == `MXC_IDX_SPARE) ? ~`MXC_SPARE_MASK : 16'h0000;
wire [31:0] rsv32 = {16'hFFFF, rsv};
wire osr_zero = oversampling_select == 2'b00;
sequence bus_wait; (avs_read || avs_write) && avs_waitrequest; endsequence
sequence bus_done; done; endsequence
sequence cleared; conv_result == 16'h0000 && sequence_step_counter == 2'b00 && !seq_busy;
endsequence
// ****************************************************************
// Assertions
// ****************************************************************
one_wait_a: assert property (bus_wait |=> bus_done)
    else $error("bus answer missing after one wait state");
cfg_mirror_a: assert property (wr_one && be_full |=> one_out == $past(one_wd))
    else $error("first config outputs differ from written value");
cfg_hold_a: assert property ($changed(one_out) |-> $past(wr_one))
    else $error("first config outputs changed without a write");
osr_mirror_a: assert property (wr_two |=> oversampling_select == $past(osr_wd))
    else $error("oversampling output differs from written value");
off_clears_a: assert property (!mux_converter_enable |=> cleared)
    else $error("disabled converter kept result or step count");
power_clears_a: assert property (power_down |=> cleared)
    else $error("power down kept result or step count");
conv_len_a: assert property (result_valid && osr_zero |-> $past(conv_start, 384))
    else $error("conversion did not last 384 cycles");
idle_count_a: assert property ($fell(seq_busy) |-> sequence_step_counter == 2'b00)
    else $error("step counter not zero when sequence stops");
reserved_zero_a: assert property (avs_read && done |-> (avs_readdata & rsv32) == 32'h00000000)
    else $error("reserved bits read nonzero");
endmodule // mxcfg_properties
`default_nettype wire

// ### verilog/mxcfg_defines.vh
/*
 Constants for the multiplexed converter configuration and sequencer block:
 register indices, field positions, reset values, masks and timing counts.
 Assumes it is included by its bare name and that an index times four is the
 byte address seen on the register bus.
*/
`ifndef MXCFG_DEFINES_VH
`define MXCFG_DEFINES_VH

// ****************************************************************
// Register indices (byte address = 4 * index)
// ****************************************************************
`define MXC_IDX_CFG_ONE 8'hCB
`define MXC_IDX_CFG_TWO 8'hCC
`define MXC_IDX_SPARE 8'hCD
`define MXC_IDX_OFFSET 8'hCE
`define MXC_IDX_GAIN 8'hCF
`define MXC_IDX_CTRL 8'hE0
`define MXC_IDX_RESULT 8'hE1

// ****************************************************************
// Reset values and writable-bit masks
// ****************************************************************
`define MXC_CFG_ONE_RST 16'h8010
`define MXC_CFG_TWO_RST 16'h0000
`define MXC_SPARE_RST 16'h0000
`define MXC_OFFSET_RST 16'h0000
`define MXC_GAIN_RST 16'h0000
`define MXC_CFG_ONE_MASK 16'h87FF
`define MXC_CFG_TWO_MASK 16'hC703
`define MXC_SPARE_MASK 16'h00FF

// ****************************************************************
// Field positions
// ****************************************************************
`define MXC_EN_BIT 15
`define MXC_CMB_BIT 10
`define MXC_SRC_ROUTE_HI 9
`define MXC_SRC_ROUTE_LO 7
`define MXC_SINK_ROUTE_HI 6
`define MXC_SINK_ROUTE_LO 4
`define MXC_SRC_LVL_HI 3
`define MXC_SRC_LVL_LO 2
`define MXC_SINK_LVL_HI 1
`define MXC_SINK_LVL_LO 0
`define MXC_MODE_HI 15
`define MXC_MODE_LO 14
`define MXC_DELAY_HI 10
`define MXC_DELAY_LO 8
`define MXC_OSR_HI 1
`define MXC_OSR_LO 0
`define MXC_START_BIT 0

// ****************************************************************
// Sequencer modes
// ****************************************************************
`define MXC_MODE_SINGLE 2'h0
`define MXC_MODE_TRIG 2'h1

// ****************************************************************
// Timing in master clock cycles
// ****************************************************************
`define MXC_SETTLE_0 13'h0010
`define MXC_SETTLE_1 13'h0040
`define MXC_SETTLE_2 13'h0080
`define MXC_SETTLE_3 13'h0100
`define MXC_SETTLE_4 13'h0200
`define MXC_SETTLE_5 13'h0400
`define MXC_SETTLE_6 13'h0800
`define MXC_SETTLE_7 13'h1000
`define MXC_CONV_0 13'h0180
`define MXC_CONV_1 13'h0200
`define MXC_CONV_2 13'h0300
`define MXC_CONV_3 13'h0500

`endif

// ### verilog/mxcfg_top.v
/*
 Configuration registers, sequencer and result calibration of the
 multiplexed 16-bit converter, reached as an Avalon-MM slave.
 Assumes raw_sample comes from the decimation filter on core_clk, that
 power_down comes from same-clock power logic, and that data_ready_n is an
 asynchronous pin from the current converter.
*/
// Our own choice: register access over Avalon-MM.
// How it works
// - Enable resets set; disable or standby clears result and step counter.
// - Bit 10 of the first configuration register turns on the common-mode buffer.
// - Bits 9:7 route the test source to inputs 0..7; reset 000b.
// - Bits 6:4 route the test sink to inputs 0..7; reset 001b.
// - Bits 3:2 set source level: off, 4, 40, 240 microamps.
// - Bits 1:0 set sink level with the same coding.
// - Setting start aborts any running sequence and restarts at step zero.
// - Mode 00b runs one pass per start, then stops.
// - Mode 01b also starts a pass on each data-ready falling edge.
// - In mode 01b data-ready edges during a pass are ignored.
// - Modes 10b and 11b repeat passes continuously after start.
// - Each enabled step waits 16 to 4096 cycles by bits 10:8 first.
// - Bits 1:0 pick oversampling; conversion lasts 384 to 1280 cycles.
// - Eight spare bits read and write freely, with no effect.
// - Offset word LSB doubles when the step gain is 4.
// - Gain word scales by one plus value times two to the minus 16.
`timescale 1ns/1ps
`default_nettype none
`include "mxcfg_defines.vh"

module mxcfg_top #(
    parameter NSTEPS = 4
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire power_down,
    input wire current_conv_data_ready_n,
    input wire [NSTEPS-1:0] step_enable,
    input wire [1:0] mux_converter_gain,
    input wire [15:0] raw_sample,
    output wire mux_converter_enable,
    output wire common_mode_buffer_enable,
    output wire [2:0] test_source_route,
    output wire [2:0] test_sink_route,
    output wire [1:0] test_source_level,
    output wire [1:0] test_sink_level,
    output wire [1:0] oversampling_select,
    output reg [1:0] sequence_step_counter,
    output reg conv_start,
    output reg result_valid,
    output reg [15:0] conv_result,
    output wire seq_busy
);

    localparam ST_IDLE = 3'b001;
    localparam ST_SETTLE = 3'b010;
    localparam ST_CONV = 3'b100;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function [12:0] settle_cycles;
        input [2:0] code;
        begin
            case (code)
                3'h0: settle_cycles = `MXC_SETTLE_0;
                3'h1: settle_cycles = `MXC_SETTLE_1;
                3'h2: settle_cycles = `MXC_SETTLE_2;
                3'h3: settle_cycles = `MXC_SETTLE_3;
                3'h4: settle_cycles = `MXC_SETTLE_4;
                3'h5: settle_cycles = `MXC_SETTLE_5;
                3'h6: settle_cycles = `MXC_SETTLE_6;
                default: settle_cycles = `MXC_SETTLE_7;
            endcase
        end
    endfunction

    function [12:0] conv_cycles;
        input [1:0] code;
        begin
            case (code)
                2'h0: conv_cycles = `MXC_CONV_0;
                2'h1: conv_cycles = `MXC_CONV_1;
                2'h2: conv_cycles = `MXC_CONV_2;
                default: conv_cycles = `MXC_CONV_3;
            endcase
        end
    endfunction

    // Merges the two low byte lanes into a 16-bit register under a mask
    function [15:0] lane_merge;
        input [15:0] old;
        input [15:0] wdata;
        input [1:0] be;
        input [15:0] mask;
        reg [15:0] lanes;
        begin
            lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
            lane_merge = (old & ~lanes) | (wdata & lanes);
        end
    endfunction

    // ****************************************************************
    // Register bus slave
    // ****************************************************************
    reg bus_ack;
    reg [15:0] cfg_one;
    reg [15:0] cfg_two;
    reg [15:0] spare_bits;
    reg [15:0] offset_trim_word;
    reg [15:0] gain_trim_word;
    reg [31:0] next_readdata;
    reg [2:0] state;

    wire [7:0] reg_index = avs_address[9:2];
    wire bus_req = avs_read | avs_write;
    wire wr_take = avs_write & bus_ack;
    wire start_req;

    // One wait cycle per access keeps read data registered
    assign avs_waitrequest = bus_req & ~bus_ack;

    always @* begin
        next_readdata = 32'h00000000;
        case (reg_index)
            `MXC_IDX_CFG_ONE: next_readdata = {16'h0000, cfg_one};
            `MXC_IDX_CFG_TWO: next_readdata = {16'h0000, cfg_two};
            `MXC_IDX_SPARE: next_readdata = {16'h0000, spare_bits};
            `MXC_IDX_OFFSET: next_readdata = {16'h0000, offset_trim_word};
            `MXC_IDX_GAIN: next_readdata = {16'h0000, gain_trim_word};
            `MXC_IDX_CTRL: next_readdata = {29'h00000000, sequence_step_counter, seq_busy};
            `MXC_IDX_RESULT: next_readdata = {16'h0000, conv_result};
            default: next_readdata = 32'h00000000;
        endcase
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            bus_ack <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
            if (avs_read & ~bus_ack) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // The block does not lock configuration while enabled; the host keeps off
    // changes during a running pass, otherwise a step sees mixed settings.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_one <= `MXC_CFG_ONE_RST;
            cfg_two <= `MXC_CFG_TWO_RST;
            spare_bits <= `MXC_SPARE_RST;
            offset_trim_word <= `MXC_OFFSET_RST;
            gain_trim_word <= `MXC_GAIN_RST;
        end else if (wr_take) begin
            case (reg_index)
                `MXC_IDX_CFG_ONE: cfg_one <= lane_merge(cfg_one, avs_writedata[15:0],
                    avs_byteenable[1:0], `MXC_CFG_ONE_MASK);
                `MXC_IDX_CFG_TWO: cfg_two <= lane_merge(cfg_two, avs_writedata[15:0],
                    avs_byteenable[1:0], `MXC_CFG_TWO_MASK);
                `MXC_IDX_SPARE: spare_bits <= lane_merge(spare_bits, avs_writedata[15:0],
                    avs_byteenable[1:0], `MXC_SPARE_MASK);
                `MXC_IDX_OFFSET: offset_trim_word <= lane_merge(offset_trim_word,
                    avs_writedata[15:0], avs_byteenable[1:0], 16'hFFFF);
                `MXC_IDX_GAIN: gain_trim_word <= lane_merge(gain_trim_word,
                    avs_writedata[15:0], avs_byteenable[1:0], 16'hFFFF);
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Configuration outputs
    // ****************************************************************
    assign mux_converter_enable = cfg_one[`MXC_EN_BIT];
    assign common_mode_buffer_enable = cfg_one[`MXC_CMB_BIT];
    assign test_source_route = cfg_one[`MXC_SRC_ROUTE_HI:`MXC_SRC_ROUTE_LO];
    assign test_sink_route = cfg_one[`MXC_SINK_ROUTE_HI:`MXC_SINK_ROUTE_LO];
    assign test_source_level = cfg_one[`MXC_SRC_LVL_HI:`MXC_SRC_LVL_LO];
    assign test_sink_level = cfg_one[`MXC_SINK_LVL_HI:`MXC_SINK_LVL_LO];
    assign oversampling_select = cfg_two[`MXC_OSR_HI:`MXC_OSR_LO];

    wire [1:0] seq_mode = cfg_two[`MXC_MODE_HI:`MXC_MODE_LO];
    wire [2:0] delay_code = cfg_two[`MXC_DELAY_HI:`MXC_DELAY_LO];
    wire seq_continuous = seq_mode[1];

    // ****************************************************************
    // Data-ready pin synchroniser and falling-edge detect
    // ****************************************************************
    reg drdy_meta;
    reg drdy_sync;
    reg drdy_prev;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            drdy_meta <= 1'b1;
            drdy_sync <= 1'b1;
            drdy_prev <= 1'b1;
        end else begin
            drdy_meta <= current_conv_data_ready_n;
            drdy_sync <= drdy_meta;
            drdy_prev <= drdy_sync;
        end
    end

    wire drdy_fall = drdy_prev & ~drdy_sync;
    assign start_req = wr_take & (reg_index == `MXC_IDX_CTRL)
        & avs_byteenable[0] & avs_writedata[`MXC_START_BIT];
    assign seq_busy = (state != ST_IDLE);
    // Only an idle sequencer takes a data-ready trigger
    wire trig_req = (seq_mode == `MXC_MODE_TRIG) & drdy_fall & ~seq_busy;

    // ****************************************************************
    // Calibration: offset first, then gain, then saturation
    // ****************************************************************
    // At gain 4 one offset LSB spans two output LSBs; at gains 1 and 2 it spans one
    wire signed [17:0] offset_scaled = mux_converter_gain[1]
        ? {offset_trim_word[15], offset_trim_word, 1'b0}
        : {{2{offset_trim_word[15]}}, offset_trim_word};
    wire signed [18:0] cal_diff = {{3{raw_sample[15]}}, raw_sample}
        - {offset_scaled[17], offset_scaled};
    wire signed [17:0] gain_factor = 18'sh10000
        + {{2{gain_trim_word[15]}}, gain_trim_word};
    wire signed [36:0] cal_prod = cal_diff * gain_factor;
    wire [20:0] cal_scaled = cal_prod[36:16];
    wire cal_fits = (cal_scaled[20:15] == 6'h00) | (cal_scaled[20:15] == 6'h3F);
    wire [15:0] cal_result = cal_fits ? cal_scaled[15:0]
        : (cal_scaled[20] ? 16'h8000 : 16'h7FFF);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    reg [12:0] timer;
    wire last_step = (sequence_step_counter == NSTEPS - 1);

    task step_advance;
        begin
            if (last_step) begin
                sequence_step_counter <= 2'h0;
                if (seq_continuous) begin
                    state <= ST_SETTLE;
                    timer <= settle_cycles(delay_code);
                end else begin
                    state <= ST_IDLE;
                end
            end else begin
                sequence_step_counter <= sequence_step_counter + 2'h1;
                state <= ST_SETTLE;
                timer <= settle_cycles(delay_code);
            end
        end
    endtask

    always @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            timer <= 13'h0000;
            sequence_step_counter <= 2'h0;
            conv_start <= 1'b0;
            result_valid <= 1'b0;
            conv_result <= 16'h0000;
        end else begin
            conv_start <= 1'b0;
            result_valid <= 1'b0;
            if (~mux_converter_enable | power_down) begin
                state <= ST_IDLE;
                sequence_step_counter <= 2'h0;
                conv_result <= 16'h0000;
            end else if (start_req | trig_req) begin
                state <= ST_SETTLE;
                sequence_step_counter <= 2'h0;
                timer <= settle_cycles(delay_code);
            end else begin
                case (state)
                    ST_IDLE: begin
                    end
                    ST_SETTLE: begin
                        // A disabled step costs one cycle and is skipped
                        if (~step_enable[sequence_step_counter]) begin
                            step_advance;
                        end else if (timer == 13'h0001) begin
                            state <= ST_CONV;
                            timer <= conv_cycles(oversampling_select);
                            conv_start <= 1'b1;
                        end else begin
                            timer <= timer - 13'h0001;
                        end
                    end
                    ST_CONV: begin
                        if (timer == 13'h0001) begin
                            conv_result <= cal_result;
                            result_valid <= 1'b1;
                            step_advance;
                        end else begin
                            timer <= timer - 13'h0001;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // mxcfg_top

`default_nettype wire
